// >>> src/dfs_map.vh
// constants for the decimation filter sequencer
`ifndef DFS_MAP_VH
`define DFS_MAP_VH
`define DFS_ADDR_CTRL 12'h000
`define DFS_ADDR_DECIM 12'h004
`define DFS_ADDR_STAT 12'h008
`define DFS_ADDR_DATA 12'h00C
`define DFS_CTRL_SPEED 0
`define DFS_CTRL_FLT_LSB 1
`define DFS_CTRL_FLT_MSB 2
`define DFS_CTRL_CHSEL 3
`define DFS_CTRL_ENABLE 4
`define DFS_CTRL_RESET 32'h0000_0000
`define DFS_DECIM_RESET 11'h0_014
`define DFS_DECIM_MIN 11'h0_014
`define DFS_DECIM_MAX 11'h7_FF
`define DFS_DIV_SLOW 8'h7F
`define DFS_DIV_FAST_SPEED0 8'h7F
`define DFS_DIV_SPEED0 9'h0_80
`define DFS_DIV_SPEED1 9'h1_00
`define DFS_FLT_FAST 2'h0
`define DFS_FLT_SINC2 2'h1
`define DFS_FLT_SINC3 2'h2
`define DFS_FLT_AUTO 2'h3
`define DFS_FIFO_DEPTH 32
`define DFS_FIFO_AW 5
`endif

// >>> src/dfs_fifo.v
// synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module dfs_fifo #(
   parameter WIDTH = 32,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   input wire pclk,
   input wire presetn,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr_reg;
   reg [AW:0] rd_ptr_reg;
   wire [AW:0] count;
   wire push;
   wire pop;
   assign count = wr_ptr_reg - rd_ptr_reg;
   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr_reg[AW-1:0]];
   always @(posedge pclk) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr_reg <= {(AW+1){1'b0}};
         rd_ptr_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule // dfs_fifo
`default_nettype wire

// >>> src/dfs_top.v
// decimation filter sequencer with apb registers and output fifo
`include "dfs_map.vh"
`timescale 1ns/100ps
`default_nettype none
module dfs_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire mod_bit,
   output wire mod_strobe,
   output reg [31:0] word_data,
   output reg word_valid,
   output wire [31:0] fifo_data,
   output wire fifo_valid,
   input wire fifo_ready
);
   localparam ST_IDLE = 3'b001;
   localparam ST_RUN = 3'b010;
   localparam ST_FLUSH = 3'b100;
   reg [31:0] ctrl_reg;
   reg [10:0] decim_reg;
   reg [8:0] div_cnt_reg;
   reg [10:0] dec_cnt_reg;
   reg [2:0] state_reg;
   reg [1:0] auto_cnt_reg;
   reg chsel_d_reg;
   reg overflow_reg;
   reg [31:0] acc1_reg;
   reg [31:0] acc2_reg;
   reg [31:0] acc3_reg;
   reg [31:0] d1_reg;
   reg [31:0] d2_reg;
   reg [31:0] d3_reg;
   reg [31:0] d2b_reg;
   reg [31:0] d3b_reg;
   reg [31:0] d3c_reg;
   reg [1:0] settle_reg;
   reg [31:0] wdata_next;
   reg [1:0] flt_next;
   wire [8:0] div_len;
   wire mod_tick;
   wire period_end;
   wire [1:0] flt_sel;
   wire chsel_edge;
   wire [31:0] in_val;
   wire [31:0] c1;
   wire [31:0] c2;
   wire [31:0] c3;
   wire [31:0] d2_x2;
   wire [31:0] d3_x3;
   wire [31:0] d3b_x3;
   wire [31:0] sinc2_word;
   wire [31:0] sinc3_word;
   wire fifo_in_ready;
   wire wr_en;
   wire rd_en;
   wire [10:0] wr_decim;
   // modulator tick from the oscillator clock
   assign div_len = ctrl_reg[`DFS_CTRL_SPEED] ? `DFS_DIV_SPEED1 :
      `DFS_DIV_SPEED0;
   assign mod_tick = (state_reg != ST_IDLE) &&
      (div_cnt_reg == div_len - 9'h0_01);
   assign mod_strobe = mod_tick;
   assign period_end = mod_tick && (dec_cnt_reg == decim_reg - 11'h0_01);
   // bit 1 counts +1, bit 0 counts -1, so the sign follows the input
   assign in_val = mod_bit ? 32'h0000_0001 : 32'hFFFF_FFFF;
   assign flt_sel = ctrl_reg[`DFS_CTRL_FLT_MSB:`DFS_CTRL_FLT_LSB];
   assign chsel_edge = ctrl_reg[`DFS_CTRL_CHSEL] != chsel_d_reg;
   // integrators at the modulator rate, combs taken at each period end
   assign c1 = acc1_reg + in_val;
   assign c2 = acc2_reg + c1;
   assign c3 = acc3_reg + c2;
   assign d2_x2 = {d2_reg[30:0], 1'b0};
   assign d3_x3 = d3_reg + {d3_reg[30:0], 1'b0};
   assign d3b_x3 = d3b_reg + {d3b_reg[30:0], 1'b0};
   // sums wrap freely; sinc3 words outgrow 32 bits above a ratio of 1290
   assign sinc2_word = c2 - d2_x2 + d2b_reg;
   assign sinc3_word = c3 - d3_x3 + d3b_x3 - d3c_reg;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_decim = (pwdata[10:0] < `DFS_DECIM_MIN) ? `DFS_DECIM_MIN :
      pwdata[10:0];
   // effective response for the current reading
   always @* begin
      flt_next = flt_sel;
      if (flt_sel == `DFS_FLT_AUTO) begin
         if (auto_cnt_reg < 2'd2) begin
            flt_next = `DFS_FLT_FAST;
         end else if (auto_cnt_reg == 2'd2) begin
            flt_next = `DFS_FLT_SINC2;
         end else begin
            flt_next = `DFS_FLT_SINC3;
         end
      end
   end
   always @* begin
      case (flt_next)
         `DFS_FLT_FAST: wdata_next = c1 - d1_reg;
         `DFS_FLT_SINC2: wdata_next = sinc2_word;
         default: wdata_next = sinc3_word;
      endcase
   end
   // apb registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= `DFS_CTRL_RESET;
         decim_reg <= `DFS_DECIM_RESET;
      end else if (wr_en) begin
         case (paddr)
            `DFS_ADDR_CTRL: ctrl_reg <= {27'h000_0000, pwdata[4:0]};
            `DFS_ADDR_DECIM: decim_reg <= wr_decim;
            default: ctrl_reg <= ctrl_reg;
         endcase
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         case (paddr)
            `DFS_ADDR_CTRL: prdata <= ctrl_reg;
            `DFS_ADDR_DECIM: prdata <= {21'h00_0000, decim_reg};
            `DFS_ADDR_STAT: prdata <= {24'h00_0000, 1'b0, state_reg,
               settle_reg, overflow_reg, fifo_valid};
            `DFS_ADDR_DATA: prdata <= word_data;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
   // sequencer: idle until enabled, flush on disable
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: if (ctrl_reg[`DFS_CTRL_ENABLE]) begin
               state_reg <= ST_RUN;
            end
            ST_RUN: if (!ctrl_reg[`DFS_CTRL_ENABLE]) begin
               state_reg <= ST_FLUSH;
            end
            ST_FLUSH: state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
   // dividers and decimation counter
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_reg <= 9'h0_00;
         dec_cnt_reg <= 11'h0_00;
      end else if (state_reg != ST_RUN) begin
         div_cnt_reg <= 9'h0_00;
         dec_cnt_reg <= 11'h0_00;
      end else begin
         div_cnt_reg <= mod_tick ? 9'h0_00 : div_cnt_reg + 9'h0_01;
         if (period_end || chsel_edge) begin
            dec_cnt_reg <= 11'h0_00;
         end else if (mod_tick) begin
            dec_cnt_reg <= dec_cnt_reg + 11'h0_01;
         end
      end
   end
   // running sums and one-period delay lines
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc1_reg <= 32'h0000_0000;
         acc2_reg <= 32'h0000_0000;
         acc3_reg <= 32'h0000_0000;
         d1_reg <= 32'h0000_0000;
         d2_reg <= 32'h0000_0000;
         d3_reg <= 32'h0000_0000;
         d2b_reg <= 32'h0000_0000;
         d3b_reg <= 32'h0000_0000;
         d3c_reg <= 32'h0000_0000;
      end else if (state_reg != ST_RUN || chsel_edge) begin
         acc1_reg <= 32'h0000_0000;
         acc2_reg <= 32'h0000_0000;
         acc3_reg <= 32'h0000_0000;
         d1_reg <= 32'h0000_0000;
         d2_reg <= 32'h0000_0000;
         d3_reg <= 32'h0000_0000;
         d2b_reg <= 32'h0000_0000;
         d3b_reg <= 32'h0000_0000;
         d3c_reg <= 32'h0000_0000;
      end else if (mod_tick) begin
         acc1_reg <= c1;
         acc2_reg <= c2;
         acc3_reg <= c3;
         if (period_end) begin
            d1_reg <= c1;
            d2_reg <= c2;
            d2b_reg <= d2_reg;
            d3_reg <= c3;
            d3b_reg <= d3_reg;
            d3c_reg <= d3b_reg;
         end
      end
   end
   // auto sequence counter and settling count
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auto_cnt_reg <= 2'd0;
         settle_reg <= 2'd0;
         chsel_d_reg <= 1'b0;
      end else begin
         chsel_d_reg <= ctrl_reg[`DFS_CTRL_CHSEL];
         if (chsel_edge || state_reg != ST_RUN) begin
            auto_cnt_reg <= 2'd0;
            settle_reg <= 2'd0;
         end else if (period_end) begin
            if (auto_cnt_reg != 2'd3) begin
               auto_cnt_reg <= auto_cnt_reg + 2'd1;
            end
            if (settle_reg != 2'd3) begin
               settle_reg <= settle_reg + 2'd1;
            end
         end
      end
   end
   // output word, strobe and overflow flag
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_data <= 32'h0000_0000;
         word_valid <= 1'b0;
         overflow_reg <= 1'b0;
      end else begin
         word_valid <= period_end && state_reg == ST_RUN;
         if (period_end && state_reg == ST_RUN) begin
            word_data <= wdata_next;
         end
         if (word_valid && !fifo_in_ready) begin
            overflow_reg <= 1'b1;
         end else if (wr_en && paddr == `DFS_ADDR_STAT && pwdata[1]) begin
            overflow_reg <= 1'b0;
         end
      end
   end
   dfs_fifo #(
      .WIDTH(32),
      .DEPTH(`DFS_FIFO_DEPTH),
      .AW(`DFS_FIFO_AW)
   ) dfs_fifo_i (
      .pclk(pclk),
      .presetn(presetn),
      .in_data(word_data),
      .in_valid(word_valid),
      .in_ready(fifo_in_ready),
      .out_data(fifo_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready)
   );
endmodule // dfs_top
`default_nettype wire

// >>> testbench/dfs_top_sva.sv
// port assertions for the filter sequencer
`timescale 1ns/100ps
`default_nettype none
module dfs_top_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic mod_strobe,
   input wire logic [31:0] word_data,
   input wire logic word_valid,
   input wire logic [31:0] fifo_data,
   input wire logic fifo_valid,
   input wire logic fifo_ready
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [8:0] gap_reg;
   logic [11:0] nstr_reg;
   wire ctrl_wr = psel && penable && pwrite && paddr == 12'h000;
   // strobe spacing and strobes per word, all-ones means not yet known
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gap_reg <= 9'h1FF;
         nstr_reg <= 12'hFFF;
      end else begin
         gap_reg <= mod_strobe ? 9'h000 : gap_reg + {8'h00, ~&gap_reg};
         if (ctrl_wr)
            nstr_reg <= 12'hFFF;
         else if (word_valid)
            nstr_reg <= {11'h000, mod_strobe};
         else if (mod_strobe && nstr_reg != 12'hFFF)
            nstr_reg <= nstr_reg + 12'h001;
      end
   end
   sequence s_wr_decim;
      psel && penable && pwrite && paddr == 12'h004 && pwdata <= 32'h0000_07FF;
   endsequence
   sequence s_rd_decim;
      psel && !penable && !pwrite && paddr == 12'h004;
   endsequence
   a_strobe_gap: assert property (
      mod_strobe |-> gap_reg inside {9'h07F, 9'h0FF, 9'h1FF})
      else $error("modulator strobe spacing off");
   a_strobe_pulse: assert property (mod_strobe |=> !mod_strobe [*8])
      else $error("modulator strobe too long");
   a_ratio_range: assert property (
      word_valid |-> nstr_reg == 12'hFFF || nstr_reg inside {[12'h014:12'h7FF]})
      else $error("decimation period out of range");
   a_valid_pulse: assert property (word_valid |=> !word_valid)
      else $error("word strobe longer than one cycle");
   a_fifo_push: assert property (word_valid |=> fifo_valid)
      else $error("word not queued");
   a_fifo_head: assert property (
      word_valid && !fifo_valid |=> fifo_data == $past(word_data))
      else $error("queued word differs");
   a_fifo_hold: assert property (
      fifo_valid && !fifo_ready |=> fifo_valid && $stable(fifo_data))
      else $error("queue head dropped while stalled");
   a_decim_clamp: assert property (
      s_wr_decim ##2 s_rd_decim |=> prdata == ($past(pwdata, 3) <
      32'h0000_0014 ? 32'h0000_0014 : $past(pwdata, 3)))
      else $error("decimation ratio not clamped");
endmodule // dfs_top_sva
bind dfs_top dfs_top_sva dfs_top_sva_i (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .mod_strobe(mod_strobe),
   .word_data(word_data), .word_valid(word_valid), .fifo_data(fifo_data),
   .fifo_valid(fifo_valid), .fifo_ready(fifo_ready));
`default_nettype wire

// >>> testbench/dfs_mod_model.sv
// modulator and serial-side model for the filter sequencer
`timescale 1ns/100ps
`default_nettype none
module dfs_mod_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic level,
   input wire logic mod_strobe,
   output logic mod_bit,
   output logic fifo_ready
);
   logic [1:0] stall_reg;
   // result stands only in the strobe cycle, inverse elsewhere
   assign mod_bit = mod_strobe ? level : ~level;
   // drain one word in three cycles, stalling in between
   assign fifo_ready = stall_reg == 2'h2;
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         stall_reg <= 2'h0;
      else
         stall_reg <= fifo_ready ? 2'h0 : stall_reg + 2'h1;
endmodule // dfs_mod_model
`default_nettype wire

// >>> testbench/dfs_top_bench.sv
// self-checking bench for the filter sequencer
`timescale 1ns/100ps
`default_nettype none
module dfs_top_bench;
   logic pclk, presetn, psel, penable, pwrite, level, mod_bit, mod_strobe;
   logic pready, pslverr, word_valid, fifo_valid, fifo_ready;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, word_data, fifo_data, rd;
   logic [31:0] w [0:4];
   logic [31:0] fast_pos, s3;
   int n_mismatch, n_checks, cyc, tgap, i;
   time t0;
   dfs_top dfs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .mod_bit(mod_bit),
      .mod_strobe(mod_strobe), .word_data(word_data),
      .word_valid(word_valid), .fifo_data(fifo_data),
      .fifo_valid(fifo_valid), .fifo_ready(fifo_ready));
   dfs_mod_model dfs_mod_model_i (.pclk(pclk), .presetn(presetn),
      .level(level), .mod_strobe(mod_strobe), .mod_bit(mod_bit),
      .fifo_ready(fifo_ready));
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc == 90000) begin
         n_mismatch++;
         conclude;
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic next_word(output logic [31:0] v);
      do @(posedge pclk); while (word_valid !== 1'b1);
      v = word_data;
      tgap = int'(($time - t0) / 40);
      t0 = $time;
      do @(posedge pclk); while ((fifo_valid && fifo_ready) !== 1'b1);
      check(fifo_data, v);
   endtask
   initial begin
      {psel, penable, pwrite, presetn} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      cyc = 0;
      n_mismatch = 0;
      n_checks = 0;
      t0 = 0;
      level = 1'b1;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(0, 12'h000, 0);
      check(rd, 32'h0000_0000);
      apb(0, 12'h004, 0);
      check(rd, 32'h0000_0014);
      apb(0, 12'h010, 0);
      check(rd, 32'h0000_0000);
      for (i = 0; i < 2; i++) begin
         apb(1, 12'h004, i ? 32'h0000_0005 : 32'h0000_07FF);
         apb(0, 12'h004, 0);
         check(rd, i ? 32'h0000_0014 : 32'h0000_07FF);
      end
      apb(1, 12'h000, 32'h0000_0010);
      for (i = 0; i < 3; i++) next_word(fast_pos);
      check(tgap, 32'h0000_0A00);
      check(!fast_pos[31] && |fast_pos, 1'h1);
      apb(0, 12'h00C, 0);
      check(rd, 32'h0000_0014);
      level <= 1'b0;
      next_word(w[1]);
      next_word(w[2]);
      check(w[1][31], 1'h1);
      check(w[2], w[1]);
      apb(1, 12'h000, 32'h0000_0014);
      for (i = 0; i < 4; i++) next_word(w[0]);
      level <= 1'b1;
      for (i = 1; i < 5; i++) next_word(w[i]);
      check(w[1][31], 1'h1);
      check(w[2] != w[3], 1'h1);
      check(w[3], w[4]);
      s3 = w[3];
      apb(1, 12'h000, 32'h0000_0012);
      for (i = 0; i < 3; i++) next_word(w[0]);
      level <= 1'b0;
      for (i = 1; i < 4; i++) next_word(w[i]);
      check(w[1] != w[2], 1'h1);
      check(w[2], w[3]);
      check(w[2][31], 1'h1);
      apb(1, 12'h000, 32'h0000_001E);
      level <= 1'b1;
      for (i = 1; i < 5; i++) next_word(w[i]);
      check(w[1], fast_pos);
      check(w[2], fast_pos);
      check(w[3], 32'h0000_0190);
      check(w[4], s3);
      apb(1, 12'h000, 32'h0000_0011);
      for (i = 0; i < 3; i++) next_word(w[0]);
      check(tgap, 32'h0000_1400);
      conclude;
   end
endmodule // dfs_top_bench
`default_nettype wire
